// ---- rtl/spc_bank_if.sv ----
`timescale 1ns/1ps
// link engine to register bank, plus the crossings to the core clock
interface spc_bank_if;
  logic                wr_en;        // write strobe, link clock
  spc_pkg::spc_addr_t  addr;         // register address of the current byte
  spc_pkg::spc_byte_t  wdata;        // byte being written
  spc_pkg::spc_byte_t  rdata;        // readback of addr
  logic                unidir;       // unidirectional_enable field
  logic                lsb_first;    // bit order field
  spc_pkg::spc_byte_t  user_buf;     // buffered user register
  logic                update_tgl;   // flips per update command
  logic                srst_tgl;     // flips per finished soft reset
  logic                init_req;     // hard reset request, core clock
  logic                init_ack;     // hard reset done, link clock
  spc_pkg::spc_byte_t  revision;     // revision code
  spc_pkg::spc_byte_t  variant;      // variant code

  modport link (output wr_en, addr, wdata, init_req, revision, variant,
                input  rdata, unidir, lsb_first, user_buf, update_tgl, srst_tgl, init_ack);
  modport bank (input  wr_en, addr, wdata, init_req, revision, variant,
                output rdata, unidir, lsb_first, user_buf, update_tgl, srst_tgl, init_ack);
endinterface : spc_bank_if

// ---- rtl/spc_cfg.svh ----
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH

// register offsets
`define SPC_OFS_PORT_CFG    13'h000
`define SPC_OFS_REVISION    13'h002
`define SPC_OFS_VARIANT     13'h003
`define SPC_OFS_READBACK    13'h004
`define SPC_OFS_USER        13'h010
`define SPC_OFS_UPDATE      13'h0ff

// field positions
`define SPC_BIT_UNIDIR      7
`define SPC_BIT_LSB_FIRST   6
`define SPC_BIT_SOFT_RESET  5
`define SPC_BIT_RD_ACTIVE   0
`define SPC_BIT_UPDATE      0
`define SPC_INSTR_RW        14
`define SPC_INSTR_LEN_HI    13
`define SPC_INSTR_LEN_LO    12

// reset values
`define SPC_RST_PORT_CFG    8'h00
`define SPC_RST_READBACK    8'h00
`define SPC_RST_USER        8'h00

// identification values, arbitrary
`define SPC_REVISION_ID     8'h5a
`define SPC_VARIANT_ID      8'h3c

// frame counts
`define SPC_INSTR_LAST      4'hf
`define SPC_BYTE_LAST       4'h7
`define SPC_BIT_MSB         3'h7

`endif

// ---- rtl/spc_pkg.sv ----
package spc_pkg;

  typedef logic [7:0]  spc_byte_t;
  typedef logic [12:0] spc_addr_t;

  typedef enum logic [1:0] {
    SPC_ST_INSTR = 2'b00,
    SPC_ST_DATA  = 2'b01,
    SPC_ST_DONE  = 2'b10
  } spc_state_t;

endpackage : spc_pkg

// ---- rtl/spc_regs.sv ----
`timescale 1ns/1ps
`include "spc_cfg.svh"
// register bank on the link clock; buffered user register and port config
module spc_regs (
  input wire logic sclk,  // link clock
  spc_bank_if.bank b      // engine and crossing signals
);

  localparam spc_pkg::spc_byte_t PORT_RST = `SPC_RST_PORT_CFG;  // port config defaults
  localparam spc_pkg::spc_byte_t RDBK_RST = `SPC_RST_READBACK;  // readback select defaults

  logic               init_s1_q;
  logic               init_s2_q;
  spc_pkg::spc_byte_t act_link_q;
  logic               unidir_q;
  logic               lsb_first_q;
  logic               srst_q;
  logic               rd_active_q;
  spc_pkg::spc_byte_t user_buf_q;
  logic               update_tgl_q;
  logic               srst_tgl_q;
  logic               ack_q;

  // sync hard reset request from the core clock
  always_ff @(posedge sclk) begin
    init_s1_q <= b.init_req;
    init_s2_q <= init_s1_q;
    ack_q     <= init_s2_q;
  end

  // port configuration survives soft reset, only hard reset clears it
  always_ff @(posedge sclk) begin
    if (init_s2_q) begin
      unidir_q    <= PORT_RST[`SPC_BIT_UNIDIR];
      lsb_first_q <= PORT_RST[`SPC_BIT_LSB_FIRST];
    end else if (b.wr_en && b.addr == `SPC_OFS_PORT_CFG) begin
      unidir_q    <= b.wdata[`SPC_BIT_UNIDIR];
      lsb_first_q <= b.wdata[`SPC_BIT_LSB_FIRST];
    end
  end

  // soft reset bit sets on the write, clears on the next link edge
  always_ff @(posedge sclk) begin
    if (init_s2_q) begin
      srst_q <= 1'b0;
    end else if (srst_q) begin
      srst_q <= 1'b0;
    end else if (b.wr_en && b.addr == `SPC_OFS_PORT_CFG) begin
      srst_q <= b.wdata[`SPC_BIT_SOFT_RESET];
    end
  end

  // internal registers return to defaults on hard or soft reset
  always_ff @(posedge sclk) begin
    if (init_s2_q || srst_q) begin
      rd_active_q <= RDBK_RST[`SPC_BIT_RD_ACTIVE];
      user_buf_q  <= `SPC_RST_USER;
    end else if (b.wr_en && b.addr == `SPC_OFS_READBACK) begin
      rd_active_q <= b.wdata[`SPC_BIT_RD_ACTIVE];
    end else if (b.wr_en && b.addr == `SPC_OFS_USER) begin
      user_buf_q  <= b.wdata;
    end
  end

  // link-side copy of the active register for readback; it follows the
  // same update and reset events as the core copy, so readback needs no word from the core clock
  always_ff @(posedge sclk) begin
    if (init_s2_q || srst_q) begin
      act_link_q <= `SPC_RST_USER;
    end else if (b.wr_en && b.addr == `SPC_OFS_UPDATE && b.wdata[`SPC_BIT_UPDATE]) begin
      act_link_q <= user_buf_q;
    end
  end

  // events toward the core clock as toggles
  always_ff @(posedge sclk) begin
    if (init_s2_q) begin
      update_tgl_q <= 1'b0;
      srst_tgl_q   <= 1'b0;
    end else begin
      if (b.wr_en && b.addr == `SPC_OFS_UPDATE && b.wdata[`SPC_BIT_UPDATE]) begin
        update_tgl_q <= ~update_tgl_q;
      end
      if (srst_q) begin
        srst_tgl_q <= ~srst_tgl_q;
      end
    end
  end

  // readback mux; mirror nibble reads as the bit reversal of the top
  always_comb begin
    unique case (b.addr)
      `SPC_OFS_PORT_CFG: b.rdata = {unidir_q, lsb_first_q, srst_q, 1'b0,
                                    1'b0, srst_q, lsb_first_q, unidir_q};
      `SPC_OFS_REVISION: b.rdata = b.revision;
      `SPC_OFS_VARIANT:  b.rdata = b.variant;
      `SPC_OFS_READBACK: b.rdata = {7'h00, rd_active_q};
      `SPC_OFS_USER:     b.rdata = rd_active_q ? act_link_q : user_buf_q;
      default:           b.rdata = 8'h00;
    endcase
  end

  assign b.unidir     = unidir_q;
  assign b.lsb_first  = lsb_first_q;
  assign b.user_buf   = user_buf_q;
  assign b.update_tgl = update_tgl_q;
  assign b.srst_tgl   = srst_tgl_q;
  assign b.init_ack   = ack_q;

endmodule : spc_regs

// ---- rtl/spc_top.sv ----
`timescale 1ns/1ps
`include "spc_cfg.svh"

module spc_top #(
  parameter logic [7:0] REVISION_ID = `SPC_REVISION_ID,  // arbitrary value
  parameter logic [7:0] VARIANT_ID  = `SPC_VARIANT_ID    // arbitrary value
) (
  input  wire logic        mclk,            // core clock, 100 MHz
  input  wire logic        reset,           // synchronous reset, active high
  input  wire logic        sclk,            // link clock from the host
  input  wire logic        cs_n,            // frame select, active low
  input  wire logic        sdio_in,         // data pin, level seen on the wire
  output logic             sdio_out,        // data pin, driven level
  output logic             sdio_oe,         // data pin, output enable
  output logic             serial_out_pin,  // separate read data pin
  output logic             serial_out_oe,   // separate read data pin enable
  input  wire logic        two_wire_mode,   // strap: two-wire mode, only forces MSB first bit order
  output logic [7:0]       user_active      // active user register
);

  spc_bank_if bank ();

  // register bank on the link clock
  spc_regs u_regs (
    .sclk (sclk),
    .b    (bank)
  );

  // ---------------------------------------------------------------
  // link clock side
  // ---------------------------------------------------------------

  logic                 tw_s1_q;
  logic                 tw_s2_q;
  logic                 lsb_eff;
  spc_pkg::spc_state_t  state_q;
  logic [3:0]           bit_cnt_q;
  logic [14:0]          instr_q;
  logic [15:0]          instr_full;
  logic [6:0]           rx_q;
  logic                 rd_q;
  logic                 stream_q;
  logic [1:0]           left_q;
  spc_pkg::spc_addr_t   addr_q;
  logic                 byte_end;
  logic                 driving;
  logic [2:0]           tx_idx;
  logic                 sdio_out_q;
  logic                 sdio_oe_q;
  logic                 so_q;
  logic                 so_oe_q;

  // two-wire strap is a pin, so it passes two flops first
  always_ff @(posedge sclk) begin
    tw_s1_q <= two_wire_mode;
    tw_s2_q <= tw_s1_q;
  end

  // effective bit order: forced MSB first in two-wire mode
  assign lsb_eff = bank.lsb_first & ~tw_s2_q;

  // complete instruction word, bits at their word positions in either bit order
  always_comb begin
    if (lsb_eff) begin
      instr_full = {sdio_in, instr_q};
    end else begin
      instr_full = {instr_q, sdio_in};
    end
  end

  assign byte_end = (state_q == spc_pkg::SPC_ST_DATA) && (bit_cnt_q == `SPC_BYTE_LAST);

  // frame sequencer; an idle select clears the frame state
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      state_q   <= spc_pkg::SPC_ST_INSTR;
      bit_cnt_q <= 4'h0;
      rd_q      <= 1'b0;
      stream_q  <= 1'b0;
      left_q    <= 2'h0;
    end else begin
      unique case (state_q)
        spc_pkg::SPC_ST_INSTR: begin
          bit_cnt_q <= bit_cnt_q + 4'h1;
          if (bit_cnt_q == `SPC_INSTR_LAST) begin
            state_q   <= spc_pkg::SPC_ST_DATA;
            bit_cnt_q <= 4'h0;
            rd_q      <= instr_full[`SPC_INSTR_RW + 1];
            stream_q  <= &instr_full[`SPC_INSTR_LEN_HI + 1:`SPC_INSTR_LEN_LO + 1];
            left_q    <= instr_full[`SPC_INSTR_LEN_HI + 1:`SPC_INSTR_LEN_LO + 1];
          end
        end
        spc_pkg::SPC_ST_DATA: begin
          bit_cnt_q <= bit_cnt_q + 4'h1;
          if (byte_end) begin
            bit_cnt_q <= 4'h0;
            if (!stream_q) begin
              if (left_q == 2'h0) begin
                state_q <= spc_pkg::SPC_ST_DONE;
              end
              left_q <= left_q - 2'h1;
            end
          end
        end
        spc_pkg::SPC_ST_DONE: begin
          bit_cnt_q <= 4'h0;
        end
        default: begin
          state_q <= spc_pkg::SPC_ST_DONE;
        end
      endcase
    end
  end

  // instruction and data shifters follow the bit order
  always_ff @(posedge sclk) begin
    if (state_q == spc_pkg::SPC_ST_INSTR) begin
      instr_q <= lsb_eff ? instr_full[15:1] : instr_full[14:0];
    end
    if (lsb_eff) begin
      rx_q <= {sdio_in, rx_q[6:1]};
    end else begin
      rx_q <= {rx_q[5:0], sdio_in};
    end
  end

  // address: loaded from the instruction, then stepped per byte
  always_ff @(posedge sclk) begin
    if (state_q == spc_pkg::SPC_ST_INSTR && bit_cnt_q == `SPC_INSTR_LAST) begin
      addr_q <= instr_full[`SPC_INSTR_LEN_LO:0];
    end else if (byte_end) begin
      if (lsb_eff) begin
        addr_q <= addr_q + 13'h0001;
      end else begin
        addr_q <= addr_q - 13'h0001;
      end
    end
  end

  // write strobe lands on the edge that takes the last bit of a byte
  assign bank.wr_en = byte_end && !rd_q && !cs_n;
  assign bank.addr  = addr_q;
  assign bank.wdata = lsb_eff ? {sdio_in, rx_q} : {rx_q, sdio_in};
  assign bank.revision = REVISION_ID;
  assign bank.variant  = VARIANT_ID;

  // read bit for the current position, launched on the falling edge
  assign driving = (state_q == spc_pkg::SPC_ST_DATA) && rd_q;
  assign tx_idx  = lsb_eff ? bit_cnt_q[2:0] : `SPC_BIT_MSB - bit_cnt_q[2:0];

  // pin drivers; the enable picks the data pin or the out pin
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      sdio_out_q <= 1'b0;
      sdio_oe_q  <= 1'b0;
      so_q       <= 1'b0;
      so_oe_q    <= 1'b0;
    end else begin
      sdio_out_q <= bank.rdata[tx_idx];
      so_q       <= bank.rdata[tx_idx];
      sdio_oe_q  <= driving && !bank.unidir;
      so_oe_q    <= driving && bank.unidir;
    end
  end

  assign sdio_out       = sdio_out_q;
  assign sdio_oe        = sdio_oe_q;
  assign serial_out_pin = so_q;
  assign serial_out_oe  = so_oe_q;

  // ---------------------------------------------------------------
  // core clock side
  // ---------------------------------------------------------------

  logic               upd_s1_q;
  logic               upd_s2_q;
  logic               upd_s3_q;
  logic               srt_s1_q;
  logic               srt_s2_q;
  logic               srt_s3_q;
  logic               ack_s1_q;
  logic               ack_s2_q;
  logic               init_req_q;
  spc_pkg::spc_byte_t active_q;

  // toggles cross on three flops each, the acknowledge on two
  always_ff @(posedge mclk) begin
    if (reset) begin
      upd_s1_q <= 1'b0;
      upd_s2_q <= 1'b0;
      upd_s3_q <= 1'b0;
      srt_s1_q <= 1'b0;
      srt_s2_q <= 1'b0;
      srt_s3_q <= 1'b0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      upd_s1_q <= bank.update_tgl;
      upd_s2_q <= upd_s1_q;
      upd_s3_q <= upd_s2_q;
      srt_s1_q <= bank.srst_tgl;
      srt_s2_q <= srt_s1_q;
      srt_s3_q <= srt_s2_q;
      ack_s1_q <= bank.init_ack;
      ack_s2_q <= ack_s1_q;
    end
  end

  // hard reset request held until the link side has applied it
  always_ff @(posedge mclk) begin
    if (reset) begin
      init_req_q <= 1'b1;
    end else if (ack_s2_q) begin
      init_req_q <= 1'b0;
    end
  end

  assign bank.init_req = init_req_q;

  // active copy; the buffer is still while an update crosses, so the
  // multi-bit copy is safe without a per-bit handshake
  always_ff @(posedge mclk) begin
    if (reset || (srt_s2_q ^ srt_s3_q)) begin
      active_q <= `SPC_RST_USER;
    end else if (upd_s2_q ^ upd_s3_q) begin
      active_q <= bank.user_buf;
    end
  end

  assign user_active = active_q;

endmodule : spc_top

// ---- test/spc_host.sv ----
`timescale 1ns/1ps
// serial host: mode 0 frames, link clock still outside frames
module spc_host (
  output logic      sclk,           // link clock, 30 ns
  output logic      cs_n,           // frame select
  output logic      sdio_in,        // data pin level
  input  wire logic sdio_out,       // device drive value
  input  wire logic sdio_oe,        // device drive enable
  input  wire logic serial_out_pin, // device read pin
  input  wire logic serial_out_oe   // device read pin enable
);
  logic lsb;  // bit order in use
  logic uni;  // read from the separate pin
  logic drv;  // host drives the data pin
  logic hd;   // host data bit

  // wire level; a released line shows the inverse of the last bit
  assign sdio_in = sdio_oe ? sdio_out : (drv ? hd : ~hd);

  // idle state; select rises once so the frame logic starts cleared
  initial begin
    sclk = 0;
    cs_n = 0;
    lsb  = 0;
    uni  = 0;
    drv  = 1;
    hd   = 0;
    #1 cs_n = 1;
  end

  // one bit: data set while low, sampled on the rising edge
  task automatic bit_io(input logic v, output logic s);
    hd = v;
    #15 sclk = 1;
    s = uni ? (serial_out_oe ? serial_out_pin : ~v) : sdio_in;
    #15 sclk = 0;
  endtask : bit_io

  // one frame: instruction then n bytes, byte k in wd[8k+:8]
  task automatic xfer(input logic rd, input logic [12:0] a, input int n,
                      input logic [15:0] wd, output logic [15:0] rv);
    logic [15:0] w;
    logic        s;
    int          k;
    w = {rd, 2'(n - 1), a};
    rv = '0;
    drv = 1;
    cs_n = 0;
    #23;  // odd setup keeps link edges off the core clock phase
    for (int i = 0; i < 16; i++) bit_io(lsb ? w[i] : w[15 - i], s);
    drv = !rd;
    for (int i = 0; i < 8 * n; i++) begin
      k = lsb ? i : (i / 8) * 8 + 7 - i % 8;
      bit_io(wd[k], s);
      rv[k] = s;
    end
    #20 cs_n = 1;
    drv = 1;
    #60;
  endtask : xfer

  // short frame of n link edges so pin synchronisers catch up
  task automatic prime(input int n);
    logic s;
    drv  = 1;
    cs_n = 0;
    #23;
    for (int i = 0; i < n; i++) bit_io(1'b1, s);
    #20 cs_n = 1;
    #60;
  endtask : prime
endmodule : spc_host

// ---- test/spc_top_asserts.sv ----
`timescale 1ns/1ps
// port-level checks of the serial config block
module spc_top_asserts (
  input wire logic       mclk,            // core clock
  input wire logic       reset,           // core reset
  input wire logic       sclk,            // link clock
  input wire logic       cs_n,            // frame select
  input wire logic       sdio_in,         // data pin level
  input wire logic       sdio_out,        // data pin drive
  input wire logic       sdio_oe,         // data pin enable
  input wire logic       serial_out_pin,  // read pin
  input wire logic       serial_out_oe,   // read pin enable
  input wire logic       two_wire_mode,   // strap
  input wire logic [7:0] user_active      // active user register
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // pin ownership and idle levels
  a_oe_exclusive: assert property (!(sdio_oe && serial_out_oe))
    else $error("both read outputs enabled");
  a_idle_quiet: assert property (cs_n && $past(cs_n) |->
    !sdio_oe && !serial_out_oe && !sdio_out && !serial_out_pin)
    else $error("outputs active outside a frame");
  a_oe_drop_timing: assert property ($fell(sdio_oe) |-> !sclk)
    else $error("data pin enable dropped while link clock high");
  a_uni_drop_timing: assert property ($fell(serial_out_oe) |-> !sclk)
    else $error("read pin enable dropped while link clock high");
  // read bits launch on the falling link edge
  a_data_on_fall: assert property ($changed(sdio_out) |-> !sclk)
    else $error("data pin moved while link clock high");
  a_sout_on_fall: assert property ($changed(serial_out_pin) |-> !sclk)
    else $error("read pin moved while link clock high");
  a_oe_in_frame: assert property ($rose(sdio_oe) || $rose(serial_out_oe)
    |-> !cs_n && !sclk)
    else $error("enable rose outside a falling edge in frame");
  // active copy only moves shortly after frame traffic
  a_active_quiet: assert property (cs_n [*8] |-> $stable(user_active))
    else $error("active register moved without an update");

  cover property ($rose(sdio_oe));
  cover property ($rose(serial_out_oe));
  cover property ($changed(user_active));
endmodule : spc_top_asserts

bind spc_top spc_top_asserts u_asserts (
  .mclk(mclk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
  .sdio_out(sdio_out), .sdio_oe(sdio_oe), .serial_out_pin(serial_out_pin),
  .serial_out_oe(serial_out_oe), .two_wire_mode(two_wire_mode),
  .user_active(user_active)
);

// ---- test/tb_spc_top.sv ----
`timescale 1ns/1ps
module tb_spc_top;
  localparam logic [7:0] REV = 8'h91;  // arbitrary value
  localparam logic [7:0] VAR = 8'h27;  // arbitrary value
  logic       mclk, reset, two_wire_mode;
  logic       sclk, cs_n, sdio_in, sdio_out, sdio_oe;
  logic       serial_out_pin, serial_out_oe;
  logic [7:0] user_active;
  int         num_errors, n_checks;

  spc_top #(.REVISION_ID(REV), .VARIANT_ID(VAR)) DUT (
    .mclk(mclk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe), .serial_out_pin(serial_out_pin),
    .serial_out_oe(serial_out_oe), .two_wire_mode(two_wire_mode),
    .user_active(user_active)
  );
  spc_host host (
    .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe), .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe)
  );

  // core clock
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end

  // byte compare
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // register write of n bytes
  task automatic wr(input logic [12:0] a, input logic [15:0] d, input int n = 1);
    logic [15:0] r;
    host.xfer(1'b0, a, n, d, r);
  endtask : wr

  // single byte read and compare
  task automatic rd(input logic [12:0] a, input logic [7:0] exp);
    logic [15:0] r;
    host.xfer(1'b1, a, 1, 16'h0000, r);
    cmp(r[7:0], exp);
  endtask : rd

  // verdict
  task automatic stop_test();
    if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  // watchdog
  initial begin
    #200000;
    num_errors++;
    stop_test();
  end

  // test sequence
  initial begin
    reset = 1;
    two_wire_mode = 0;
    num_errors = 0;
    n_checks = 0;
    repeat (10) @(posedge mclk);
    reset <= 0;
    repeat (3) @(posedge mclk);
    rd(13'h002, REV);
    rd(13'h003, VAR);
    rd(13'h000, 8'h00);
    rd(13'h004, 8'h00);
    wr(13'h002, 16'h00ff);
    rd(13'h002, REV);
    // buffered write, then update command
    wr(13'h010, 16'h00a5);
    rd(13'h010, 8'ha5);
    cmp(user_active, 8'h00);
    wr(13'h0ff, 16'h0001);
    repeat (8) @(posedge mclk);
    cmp(user_active, 8'ha5);
    wr(13'h010, 16'h003c);
    wr(13'h004, 16'h0001);
    rd(13'h010, 8'ha5);
    wr(13'h004, 16'h0000);
    rd(13'h010, 8'h3c);
    // two bytes msb first: 0x011 then 0x010
    wr(13'h011, 16'h5b77, 2);
    rd(13'h010, 8'h5b);
    // soft reset together with lsb first, nibble mirrored
    wr(13'h004, 16'h0001);
    wr(13'h000, 16'h0066);
    host.lsb = 1;
    rd(13'h000, 8'h42);
    rd(13'h004, 8'h00);
    rd(13'h010, 8'h00);
    repeat (8) @(posedge mclk);
    cmp(user_active, 8'h00);
    // two bytes lsb first: 0x00f then 0x010
    wr(13'h00f, 16'hc311, 2);
    rd(13'h010, 8'hc3);
    // unidirectional reads on the separate pin
    wr(13'h000, 16'h00c3);
    host.uni = 1;
    rd(13'h003, VAR);
    rd(13'h000, 8'hc3);
    // two-wire strap forces msb first
    @(posedge mclk) two_wire_mode <= 1;
    host.lsb = 0;
    host.prime(2);
    rd(13'h002, REV);
    @(posedge mclk) two_wire_mode <= 0;
    stop_test();
  end
endmodule : tb_spc_top
